// ### hdl/dmc_pkg.sv
// Shared constants for the display memory control block.
`default_nettype none
package dmc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // Register indexes on the indexed register port.
  localparam logic [7:0] IDX_MEM_CTRL = 8'h60;
  localparam logic [7:0] IDX_BANK_HIGH = 8'h61;
  localparam logic [7:0] IDX_TYPE_TIMING = 8'h62;
  localparam logic [7:0] MEM_CTRL_RESET = 8'h00;
  localparam logic [7:0] BANK_HIGH_RESET = 8'h00;
  localparam logic [7:0] MEM_CTRL_WMASK = 8'h3B;
  // Control register bit positions.
  localparam int BIT_PAL_WIDE = 5;
  localparam int BIT_BURST_OFF = 4;
  localparam int BIT_REFILL_SEL = 3;
  localparam int BIT_REF_OFF = 1;
  localparam int BIT_REF_LINE = 0;
  // Type and timing register bit positions.
  localparam int BIT_CORE_RATE = 7;
  localparam int BIT_BUS_WIDTH = 6;
  localparam int BIT_COL_HI = 5;
  localparam int BIT_COL_LO = 4;
  localparam int BIT_OFFCHIP_OFF = 2;
  localparam int BIT_ACT_PRE = 1;
  localparam int BIT_REF_CMD = 0;
  // Palette command pulse, in memory clocks.
  localparam logic [4:0] PAL_HIGH_NARROW = 5'h04;
  localparam logic [4:0] PAL_LOW_NARROW = 5'h0C;
  localparam logic [4:0] PAL_HIGH_WIDE = 5'h08;
  localparam logic [4:0] PAL_LOW_WIDE = 5'h18;
  // External memory delays, in memory clocks.
  localparam logic [3:0] ACT_PRE_SLOW = 4'h7;
  localparam logic [3:0] ACT_PRE_FAST = 4'h6;
  localparam logic [3:0] REF_CMD_SLOW = 4'hA;
  localparam logic [3:0] REF_CMD_FAST = 4'h9;
  // Column address widths.
  localparam logic [3:0] COL_BITS_8 = 4'h8;
  localparam logic [3:0] COL_BITS_9 = 4'h9;
  localparam logic [3:0] COL_BITS_10 = 4'hA;
  // Normal refresh interval.
  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam logic [11:0] REFRESH_CYCLES = 12'(REFRESH_INTERVAL_NS / CLK_PERIOD_NS);
  // Display fetch FIFO.
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 32;
  localparam logic [3:0] REFILL_EMPTY_LO = 4'h2;
  localparam logic [3:0] REFILL_EMPTY_HI = 4'h4;
  // Memory command codes.
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACT = 3'h1;
  localparam logic [2:0] CMD_RD = 3'h2;
  localparam logic [2:0] CMD_WR = 3'h3;
  localparam logic [2:0] CMD_PRE = 3'h4;
  localparam logic [2:0] CMD_REF = 3'h5;
endpackage : dmc_pkg
`default_nettype wire

// ### hdl/dmc_fetch_fifo.sv
// Eight-entry display fetch FIFO with a programmable refill request.
`default_nettype none
module dmc_fetch_fifo (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Fill side.
  input wire logic push_i,
  input wire logic [dmc_pkg::FIFO_WIDTH-1:0] push_data_i,
  output logic push_ready_o,
  // Drain side.
  input wire logic pop_i,
  output logic [dmc_pkg::FIFO_WIDTH-1:0] pop_data_o,
  output logic pop_valid_o,
  output logic not_empty_o,
  // Refill control.
  input wire logic refill_four_i,
  output logic refill_req_o
);
  logic [dmc_pkg::FIFO_WIDTH-1:0] mem_r [dmc_pkg::FIFO_DEPTH];
  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic [3:0] count_r;
  logic [3:0] count_nxt;
  logic do_push;
  logic do_pop;
  logic [3:0] thresh;

  assign do_push = push_i && push_ready_o;
  assign do_pop = pop_i && not_empty_o;
  assign thresh = refill_four_i ? dmc_pkg::REFILL_EMPTY_HI : dmc_pkg::REFILL_EMPTY_LO;

  always_comb begin
    count_nxt = count_r;
    if (do_push && !do_pop) begin
      count_nxt = count_r + 4'h1;
    end else if (do_pop && !do_push) begin
      count_nxt = count_r - 4'h1;
    end
  end

  // Storage is plain flops; no reset needed on the data words.
  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= push_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
      count_r <= 4'h0;
      push_ready_o <= 1'b0;
      not_empty_o <= 1'b0;
      refill_req_o <= 1'b0;
      pop_valid_o <= 1'b0;
      pop_data_o <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + 3'(do_push);
      rd_ptr_r <= rd_ptr_r + 3'(do_pop);
      count_r <= count_nxt;
      push_ready_o <= count_nxt != 4'(dmc_pkg::FIFO_DEPTH);
      not_empty_o <= count_nxt != 4'h0;
      // The threshold is compared against the empty slots after this cycle.
      refill_req_o <= (4'(dmc_pkg::FIFO_DEPTH) - count_nxt) >= thresh;
      pop_valid_o <= do_pop;
      if (do_pop) begin
        pop_data_o <= mem_r[rd_ptr_r];
      end
    end
  end

  // The flag is cleared by reset and only set on the first edge after it, so that edge is skipped.
  property p_refill_level;
    @(posedge clock_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> refill_req_o == ((4'(dmc_pkg::FIFO_DEPTH) - count_r) >= $past(thresh));
  endproperty
  a_refill_level : assert property (p_refill_level)
    else $error("Refill request does not match empty level.");
  property p_never_over;
    @(posedge clock_i) disable iff (!rst_n_i) count_r <= 4'(dmc_pkg::FIFO_DEPTH);
  endproperty
  a_never_over : assert property (p_never_over) else $error("FIFO count above eight.");
  c_fifo_full : cover property (@(posedge clock_i) disable iff (!rst_n_i) !push_ready_o);
endmodule : dmc_fetch_fifo
`default_nettype wire

// ### hdl/dmc_top.sv
// Display memory control: registers, strap capture, palette pulse, refresh and memory sequencer.
`default_nettype none
module dmc_top (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Indexed register port.
  input wire logic [7:0] reg_index_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Power-on straps and system inputs.
  input wire logic [7:0] strap_data_bus_i,
  input wire logic linear_addressing_ctrl_i,
  input wire logic line_start_i,
  // Host address.
  input wire logic [15:0] host_addr_i,
  input wire logic [21:0] host_lin_addr_i,
  output logic [21:0] mem_addr_o,
  // Palette command.
  input wire logic pal_req_i,
  output logic pal_cmd_o,
  output logic pal_busy_o,
  // Display burst write.
  input wire logic burst_req_i,
  output logic burst_go_o,
  // External memory cycles.
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  output logic mem_busy_o,
  output logic mem_done_o,
  output logic [2:0] mem_cmd_o,
  // Memory mode outputs.
  output logic core_en_o,
  output logic bus_wide_o,
  output logic [3:0] col_bits_o,
  output logic offchip_on_o,
  // Display fetch FIFO.
  input wire logic fifo_push_i,
  input wire logic [dmc_pkg::FIFO_WIDTH-1:0] fifo_push_data_i,
  output logic fifo_push_ready_o,
  input wire logic fifo_pop_i,
  output logic [dmc_pkg::FIFO_WIDTH-1:0] fifo_pop_data_o,
  output logic fifo_pop_valid_o,
  output logic fifo_not_empty_o,
  output logic fifo_refill_req_o
);
  typedef enum logic [2:0] {
    PAL_IDLE = 3'b001,
    PAL_HIGH = 3'b010,
    PAL_LOW = 3'b100
  } dmc_pal_t;
  typedef enum logic [5:0] {
    SEQ_IDLE = 6'b000001,
    SEQ_ACT = 6'b000010,
    SEQ_RAS = 6'b000100,
    SEQ_PRE = 6'b001000,
    SEQ_RFC = 6'b010000,
    SEQ_OFF = 6'b100000
  } dmc_seq_t;

  logic [7:0] mem_ctrl_r;
  logic [7:0] bank_high_r;
  logic [7:0] type_timing_r;
  logic strap_done_r;
  dmc_pal_t pal_r;
  logic [4:0] pal_cnt_r;
  dmc_seq_t seq_r;
  logic [3:0] seq_cnt_r;
  logic seq_we_r;
  logic [11:0] ref_cnt_r;
  logic ref_pend_r;
  logic ref_set;
  logic ref_take;

  // Register writes; reserved control bits are not stored and read as zero.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ctrl_r <= dmc_pkg::MEM_CTRL_RESET;
      bank_high_r <= dmc_pkg::BANK_HIGH_RESET;
    end else if (reg_wr_i) begin
      if (reg_index_i == dmc_pkg::IDX_MEM_CTRL) begin
        mem_ctrl_r <= reg_wdata_i & dmc_pkg::MEM_CTRL_WMASK;
      end
      if (reg_index_i == dmc_pkg::IDX_BANK_HIGH) begin
        bank_high_r <= reg_wdata_i;
      end
    end
  end

  // The strap bus is caught on the first edge after reset release, not by the reset itself.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_done_r <= 1'b0;
      type_timing_r <= 8'h00;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      type_timing_r <= strap_data_bus_i;
    end else if (reg_wr_i && reg_index_i == dmc_pkg::IDX_TYPE_TIMING) begin
      type_timing_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_index_i)
        dmc_pkg::IDX_MEM_CTRL: reg_rdata_o <= mem_ctrl_r;
        dmc_pkg::IDX_BANK_HIGH: reg_rdata_o <= bank_high_r;
        dmc_pkg::IDX_TYPE_TIMING: reg_rdata_o <= type_timing_r;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Mode outputs are registered from the timing register, one clock behind it.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_en_o <= 1'b0;
      bus_wide_o <= 1'b0;
      col_bits_o <= dmc_pkg::COL_BITS_10;
      offchip_on_o <= 1'b0;
    end else begin
      // At half rate the core enable alternates every clock.
      core_en_o <= type_timing_r[dmc_pkg::BIT_CORE_RATE] | ~core_en_o;
      bus_wide_o <= type_timing_r[dmc_pkg::BIT_BUS_WIDTH];
      offchip_on_o <= ~type_timing_r[dmc_pkg::BIT_OFFCHIP_OFF];
      case (type_timing_r[dmc_pkg::BIT_COL_HI:dmc_pkg::BIT_COL_LO])
        2'b10: col_bits_o <= dmc_pkg::COL_BITS_8;
        2'b11: col_bits_o <= dmc_pkg::COL_BITS_9;
        default: col_bits_o <= dmc_pkg::COL_BITS_10;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_o <= 22'h00_0000;
    end else if (!linear_addressing_ctrl_i) begin
      mem_addr_o <= {bank_high_r[5:0], host_addr_i};
    end else begin
      mem_addr_o <= host_lin_addr_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      burst_go_o <= 1'b0;
    end else begin
      burst_go_o <= burst_req_i && !mem_ctrl_r[dmc_pkg::BIT_BURST_OFF];
    end
  end

  // Palette pulse; the width is latched at the start so a mid-pulse write cannot stretch it.
  logic pal_wide_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pal_r <= PAL_IDLE;
      pal_cnt_r <= 5'h00;
      pal_wide_r <= 1'b0;
      pal_cmd_o <= 1'b0;
      pal_busy_o <= 1'b0;
    end else begin
      case (pal_r)
        PAL_IDLE: begin
          if (pal_req_i) begin
            pal_wide_r <= mem_ctrl_r[dmc_pkg::BIT_PAL_WIDE];
            pal_cnt_r <= mem_ctrl_r[dmc_pkg::BIT_PAL_WIDE] ? dmc_pkg::PAL_HIGH_WIDE
                                                          : dmc_pkg::PAL_HIGH_NARROW;
            pal_cmd_o <= 1'b1;
            pal_busy_o <= 1'b1;
            pal_r <= PAL_HIGH;
          end
        end
        PAL_HIGH: begin
          if (pal_cnt_r == 5'h01) begin
            pal_cnt_r <= pal_wide_r ? dmc_pkg::PAL_LOW_WIDE : dmc_pkg::PAL_LOW_NARROW;
            pal_cmd_o <= 1'b0;
            pal_r <= PAL_LOW;
          end else begin
            pal_cnt_r <= pal_cnt_r - 5'h01;
          end
        end
        PAL_LOW: begin
          if (pal_cnt_r == 5'h01) begin
            pal_busy_o <= 1'b0;
            pal_r <= PAL_IDLE;
          end else begin
            pal_cnt_r <= pal_cnt_r - 5'h01;
          end
        end
        default: begin
          pal_r <= PAL_IDLE;
          pal_cmd_o <= 1'b0;
          pal_busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Refresh scheduling: interval timer, or one per scan line when forced.
  assign ref_set = !mem_ctrl_r[dmc_pkg::BIT_REF_OFF] &&
                   (mem_ctrl_r[dmc_pkg::BIT_REF_LINE] ? line_start_i
                                                      : ref_cnt_r == 12'h001);
  assign ref_take = seq_r == SEQ_IDLE && ref_pend_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_cnt_r <= dmc_pkg::REFRESH_CYCLES;
      ref_pend_r <= 1'b0;
    end else begin
      if (ref_cnt_r == 12'h001 || mem_ctrl_r[dmc_pkg::BIT_REF_LINE]) begin
        ref_cnt_r <= dmc_pkg::REFRESH_CYCLES;
      end else begin
        ref_cnt_r <= ref_cnt_r - 12'h001;
      end
      // A new request in the cycle the old one is taken is kept.
      if (ref_set) begin
        ref_pend_r <= 1'b1;
      end else if (ref_take || mem_ctrl_r[dmc_pkg::BIT_REF_OFF]) begin
        ref_pend_r <= 1'b0;
      end
    end
  end

  // Memory sequencer; delays are latched when a cycle starts.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seq_r <= SEQ_IDLE;
      seq_cnt_r <= 4'h0;
      seq_we_r <= 1'b0;
      mem_cmd_o <= dmc_pkg::CMD_NOP;
      mem_busy_o <= 1'b0;
      mem_done_o <= 1'b0;
    end else begin
      mem_done_o <= 1'b0;
      mem_cmd_o <= dmc_pkg::CMD_NOP;
      case (seq_r)
        SEQ_IDLE: begin
          if (type_timing_r[dmc_pkg::BIT_OFFCHIP_OFF]) begin
            seq_r <= SEQ_OFF;
          end else if (ref_pend_r) begin
            mem_cmd_o <= dmc_pkg::CMD_REF;
            mem_busy_o <= 1'b1;
            seq_cnt_r <= type_timing_r[dmc_pkg::BIT_REF_CMD] ? dmc_pkg::REF_CMD_FAST
                                                             : dmc_pkg::REF_CMD_SLOW;
            seq_r <= SEQ_RFC;
          end else if (mem_req_i) begin
            mem_cmd_o <= dmc_pkg::CMD_ACT;
            mem_busy_o <= 1'b1;
            seq_we_r <= mem_we_i;
            seq_cnt_r <= type_timing_r[dmc_pkg::BIT_ACT_PRE] ? dmc_pkg::ACT_PRE_FAST
                                                             : dmc_pkg::ACT_PRE_SLOW;
            seq_r <= SEQ_ACT;
          end
        end
        SEQ_ACT: begin
          mem_cmd_o <= seq_we_r ? dmc_pkg::CMD_WR : dmc_pkg::CMD_RD;
          seq_cnt_r <= seq_cnt_r - 4'h1;
          seq_r <= SEQ_RAS;
        end
        SEQ_RAS: begin
          if (seq_cnt_r == 4'h1) begin
            mem_cmd_o <= dmc_pkg::CMD_PRE;
            seq_r <= SEQ_PRE;
          end else begin
            seq_cnt_r <= seq_cnt_r - 4'h1;
          end
        end
        SEQ_PRE: begin
          mem_busy_o <= 1'b0;
          mem_done_o <= 1'b1;
          seq_r <= SEQ_IDLE;
        end
        SEQ_RFC: begin
          if (seq_cnt_r == 4'h1) begin
            mem_busy_o <= 1'b0;
            seq_r <= SEQ_IDLE;
          end else begin
            seq_cnt_r <= seq_cnt_r - 4'h1;
          end
        end
        SEQ_OFF: begin
          // With external memory off, requests complete with no command on the pins.
          mem_done_o <= mem_req_i;
          if (!type_timing_r[dmc_pkg::BIT_OFFCHIP_OFF]) begin
            seq_r <= SEQ_IDLE;
          end
        end
        default: begin
          seq_r <= SEQ_IDLE;
          mem_busy_o <= 1'b0;
        end
      endcase
    end
  end

  dmc_fetch_fifo u_fifo (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .push_i(fifo_push_i),
    .push_data_i(fifo_push_data_i),
    .push_ready_o(fifo_push_ready_o),
    .pop_i(fifo_pop_i),
    .pop_data_o(fifo_pop_data_o),
    .pop_valid_o(fifo_pop_valid_o),
    .not_empty_o(fifo_not_empty_o),
    .refill_four_i(mem_ctrl_r[dmc_pkg::BIT_REFILL_SEL]),
    .refill_req_o(fifo_refill_req_o)
  );

  // Checks.
  property p_pal_narrow;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(pal_cmd_o) && !pal_wide_r |-> pal_cmd_o [*4] ##1 (!pal_cmd_o && pal_busy_o) [*8]
      ##1 (pal_busy_o [*4]) ##1 !pal_busy_o;
  endproperty
  a_pal_narrow : assert property (p_pal_narrow) else $error("Narrow palette pulse wrong.");
  property p_pal_wide;
    @(posedge clock_i) disable iff (!rst_n_i)
      $rose(pal_cmd_o) && pal_wide_r |-> pal_cmd_o [*8] ##1 !pal_cmd_o ##23 !pal_cmd_o
      ##1 !pal_busy_o;
  endproperty
  a_pal_wide : assert property (p_pal_wide) else $error("Wide palette pulse wrong.");
  property p_burst_off;
    @(posedge clock_i) disable iff (!rst_n_i)
      burst_req_i && mem_ctrl_r[dmc_pkg::BIT_BURST_OFF] |=> !burst_go_o;
  endproperty
  a_burst_off : assert property (p_burst_off) else $error("Burst passed while off.");
  property p_ref_off;
    @(posedge clock_i) disable iff (!rst_n_i)
      mem_ctrl_r[dmc_pkg::BIT_REF_OFF] && $past(mem_ctrl_r[dmc_pkg::BIT_REF_OFF])
      |=> mem_cmd_o != dmc_pkg::CMD_REF;
  endproperty
  a_ref_off : assert property (p_ref_off) else $error("Refresh while disabled.");
  property p_ref_line;
    @(posedge clock_i) disable iff (!rst_n_i)
      line_start_i && mem_ctrl_r[dmc_pkg::BIT_REF_LINE] && !mem_ctrl_r[dmc_pkg::BIT_REF_OFF]
      |=> ref_pend_r;
  endproperty
  a_ref_line : assert property (p_ref_line) else $error("Line refresh not requested.");
  property p_bank_addr;
    @(posedge clock_i) disable iff (!rst_n_i)
      !linear_addressing_ctrl_i |=> mem_addr_o == {$past(bank_high_r[5:0]), $past(host_addr_i)};
  endproperty
  a_bank_addr : assert property (p_bank_addr) else $error("Banked address wrong.");
  property p_strap;
    @(posedge clock_i) disable iff (!rst_n_i)
      !strap_done_r |=> type_timing_r == $past(strap_data_bus_i);
  endproperty
  a_strap : assert property (p_strap) else $error("Strap value not loaded.");
  property p_half_rate;
    @(posedge clock_i) disable iff (!rst_n_i)
      !type_timing_r[dmc_pkg::BIT_CORE_RATE] && !$past(type_timing_r[dmc_pkg::BIT_CORE_RATE])
      && strap_done_r |=> core_en_o != $past(core_en_o);
  endproperty
  a_half_rate : assert property (p_half_rate) else $error("Core enable not halved.");
  property p_act_pre;
    @(posedge clock_i) disable iff (!rst_n_i)
      mem_cmd_o == dmc_pkg::CMD_ACT && !type_timing_r[dmc_pkg::BIT_ACT_PRE]
      && $stable(type_timing_r) |-> ##7 mem_cmd_o == dmc_pkg::CMD_PRE;
  endproperty
  a_act_pre : assert property (p_act_pre) else $error("Activate to precharge wrong.");
  property p_ref_gap;
    @(posedge clock_i) disable iff (!rst_n_i)
      mem_cmd_o == dmc_pkg::CMD_REF |=> (mem_cmd_o == dmc_pkg::CMD_NOP) [*8];
  endproperty
  a_ref_gap : assert property (p_ref_gap) else $error("Command too soon after refresh.");
  property p_reset_zero;
    @(posedge clock_i) $rose(rst_n_i) |-> mem_ctrl_r == 8'h00 && bank_high_r == 8'h00;
  endproperty
  a_reset_zero : assert property (p_reset_zero) else $error("Registers not zero after reset.");
  c_pal_wide : cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(pal_cmd_o) && pal_wide_r);
  c_refresh : cover property (@(posedge clock_i) disable iff (!rst_n_i) mem_cmd_o == dmc_pkg::CMD_REF);
  c_precharge : cover property (@(posedge clock_i) disable iff (!rst_n_i) mem_cmd_o == dmc_pkg::CMD_PRE);
endmodule : dmc_top
`default_nettype wire

// ### tb/dmc_mem_model.sv
// Far-side memory model: power-on strap levels and command timing watch.
`default_nettype none
module dmc_mem_model #(
  parameter logic [7:0] STRAP = 8'hA3
) (
  // Clock and reset.
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Memory side.
  input wire logic [2:0] mem_cmd_i,
  output logic [7:0] strap_data_bus_o,
  output logic [7:0] act_pre_gap_o,
  output logic [7:0] ref_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strapped_r;
  logic [7:0] gap_r;
  // Straps stand only into the capture edge; a late sample then sees the inverse.
  assign strap_data_bus_o = strapped_r ? ~STRAP : STRAP;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strapped_r <= 1'b0;
      gap_r <= 8'h00;
      act_pre_gap_o <= 8'h00;
      ref_count_o <= 8'h00;
    end else begin
      strapped_r <= 1'b1;
      gap_r <= (mem_cmd_i == dmc_pkg::CMD_ACT) ? 8'h01 : gap_r + 8'h01;
      if (mem_cmd_i == dmc_pkg::CMD_PRE) begin
        act_pre_gap_o <= gap_r;
      end
      if (mem_cmd_i == dmc_pkg::CMD_REF) begin
        ref_count_o <= ref_count_o + 8'h01;
      end
    end
  end
endmodule : dmc_mem_model
`default_nettype wire

// ### tb/dmc_tb_top.sv
// Self-checking testbench for the display memory control block.
`default_nettype none
module dmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, reg_wr_i, reg_rd_i, linear_addressing_ctrl_i, line_start_i;
  logic pal_req_i, pal_cmd_o, pal_busy_o, burst_req_i, burst_go_o, mem_req_i, mem_we_i;
  logic mem_busy_o, mem_done_o, core_en_o, bus_wide_o, offchip_on_o, fifo_push_i;
  logic fifo_push_ready_o, fifo_pop_i, fifo_pop_valid_o, fifo_not_empty_o, fifo_refill_req_o;
  logic [7:0] reg_index_i, reg_wdata_i, reg_rdata_o, strap_data_bus_i, gap, refc, c;
  logic [15:0] host_addr_i;
  logic [21:0] host_lin_addr_i, mem_addr_o;
  logic [2:0] mem_cmd_o;
  logic [3:0] col_bits_o;
  logic [31:0] fifo_push_data_i, fifo_pop_data_o, hi, bz, seq;
  int miscompares = 0;
  int n_checks = 0;
  // Index, write data, read-back, then {bus_wide, offchip_on, col_bits}.
  logic [31:0] rows [7] = '{32'h60FF_3B18, 32'h615A_5A18, 32'h7F12_0018, 32'h6270_7039,
                            32'h6204_040A, 32'h6293_931A, 32'h6000_001A};
  dmc_top dut (.clock_i, .rst_n_i, .reg_index_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .strap_data_bus_i, .linear_addressing_ctrl_i, .line_start_i, .host_addr_i,
    .host_lin_addr_i, .mem_addr_o, .pal_req_i, .pal_cmd_o, .pal_busy_o, .burst_req_i,
    .burst_go_o, .mem_req_i, .mem_we_i, .mem_busy_o, .mem_done_o, .mem_cmd_o, .core_en_o,
    .bus_wide_o, .col_bits_o, .offchip_on_o, .fifo_push_i, .fifo_push_data_i,
    .fifo_push_ready_o, .fifo_pop_i, .fifo_pop_data_o, .fifo_pop_valid_o, .fifo_not_empty_o,
    .fifo_refill_req_o);
  dmc_mem_model mem (.clock_i, .rst_n_i, .mem_cmd_i(mem_cmd_o),
    .strap_data_bus_o(strap_data_bus_i), .act_pre_gap_o(gap), .ref_count_o(refc));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  task wr(input logic [7:0] i, input logic [7:0] d);
    reg_index_i = i;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
  endtask : wr
  task rd(input logic [7:0] i, input logic [7:0] e);
    reg_index_i = i;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    cyc(1);
    chk(32'(reg_rdata_o), 32'(e));
  endtask : rd
  task push_n(input int n);
    fifo_push_i = 1'b1;
    repeat (n) begin
      fifo_push_data_i = seq;
      seq = seq + 32'h0000_0001;
      cyc(1);
    end
    fifo_push_i = 1'b0;
    cyc(1);
  endtask : push_n
  task summarize;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  initial begin
    #200_000;
    miscompares++;
    summarize();
  end
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, linear_addressing_ctrl_i, line_start_i, pal_req_i} = '0;
    {burst_req_i, mem_req_i, mem_we_i, fifo_push_i, fifo_pop_i, reg_index_i} = '0;
    {reg_wdata_i, host_addr_i, host_lin_addr_i, fifo_push_data_i} = '0;
    seq = 32'hC0DE_0000;
    cyc(5);
    rst_n_i = 1'b1;
    cyc(1);
    rd(dmc_pkg::IDX_MEM_CTRL, dmc_pkg::MEM_CTRL_RESET);
    rd(dmc_pkg::IDX_BANK_HIGH, dmc_pkg::BANK_HIGH_RESET);
    rd(dmc_pkg::IDX_TYPE_TIMING, 8'hA3);
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], rows[i][15:8]);
      chk(32'({bus_wide_o, offchip_on_o, col_bits_o}), 32'(rows[i][5:0]));
    end
    host_addr_i = 16'h1234;
    host_lin_addr_i = 22'h3A_BCDE;
    cyc(2);
    chk(32'(mem_addr_o), 32'h001A_1234);
    linear_addressing_ctrl_i = 1'b1;
    cyc(2);
    chk(32'(mem_addr_o), 32'h003A_BCDE);
    for (int k = 0; k < 2; k++) begin
      wr(dmc_pkg::IDX_TYPE_TIMING, k ? 8'h93 : 8'h91);
      mem_we_i = k[0];
      mem_req_i = 1'b1;
      for (int n = 0; n < 60 && mem_done_o !== 1'b1; n++) cyc(1);
      chk(32'(mem_done_o), 32'h1);
      mem_req_i = 1'b0;
      chk(32'(gap), k ? 32'(dmc_pkg::ACT_PRE_FAST) : 32'(dmc_pkg::ACT_PRE_SLOW));
    end
    // Half rate and external memory off; the wait covers a refresh that may already be running.
    wr(dmc_pkg::IDX_TYPE_TIMING, 8'h04);
    c[0] = core_en_o;
    cyc(1);
    chk(32'({c[0] ^ core_en_o, offchip_on_o}), 32'h2);
    mem_req_i = 1'b1;
    cyc(14);
    chk(32'({mem_done_o, mem_busy_o, mem_cmd_o}), 32'h10);
    mem_req_i = 1'b0;
    wr(dmc_pkg::IDX_TYPE_TIMING, 8'h93);
    burst_req_i = 1'b1;
    for (int w = 0; w < 2; w++) begin
      wr(dmc_pkg::IDX_MEM_CTRL, w ? 8'h30 : 8'h00);
      cyc(2);
      chk(32'(burst_go_o), w ? 32'h0 : 32'h1);
      pal_req_i = 1'b1;
      cyc(1);
      pal_req_i = 1'b0;
      hi = 32'h0;
      bz = 32'h0;
      repeat (40) begin
        hi = hi + 32'(pal_cmd_o);
        bz = bz + 32'(pal_busy_o);
        cyc(1);
      end
      chk(hi, w ? 32'(dmc_pkg::PAL_HIGH_WIDE) : 32'(dmc_pkg::PAL_HIGH_NARROW));
      chk(bz, w ? 32'h0000_0020 : 32'h0000_0010);
    end
    for (int s = 0; s < 2; s++) begin
      wr(dmc_pkg::IDX_MEM_CTRL, s ? 8'h08 : 8'h00);
      push_n(5);
      chk(32'(fifo_refill_req_o), s ? 32'h0 : 32'h1);
      push_n(3);
      chk(32'({fifo_push_ready_o, fifo_refill_req_o}), 32'h0);
      repeat (8) begin
        fifo_pop_i = 1'b1;
        cyc(1);
        fifo_pop_i = 1'b0;
        chk(32'(fifo_pop_valid_o), 32'h1);
        cyc(1);
        chk(fifo_pop_data_o, seq - 32'h0000_0008);
        seq = seq + 32'h0000_0001;
      end
      chk(32'({fifo_not_empty_o, fifo_refill_req_o}), 32'h1);
      seq = seq - 32'h0000_0008;
    end
    // Refresh counts run over a whole normal interval so a missed request would show.
    wr(dmc_pkg::IDX_MEM_CTRL, 8'h02);
    // A refresh already pending at the write may still go out; let it land first.
    cyc(2);
    c = refc;
    cyc(1700);
    chk(32'(refc), 32'(c));
    wr(dmc_pkg::IDX_MEM_CTRL, 8'h00);
    cyc(1700);
    chk(32'(refc > c), 32'h1);
    wr(dmc_pkg::IDX_MEM_CTRL, 8'h01);
    cyc(2);
    c = refc;
    repeat (3) begin
      line_start_i = 1'b1;
      cyc(1);
      line_start_i = 1'b0;
      cyc(300);
    end
    chk(32'(refc - c), 32'h3);
    summarize();
  end
endmodule : dmc_tb_top
`default_nettype wire
